// ==== logic/por_seq_pkg.sv ====
// Shared constants and types for the power-on reset sequencer
package por_seq_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_KHZ    = 100000;            // 100 MHz clock
  localparam int unsigned WAIT_MS    = 5;                 // Each stabilisation wait
  localparam int unsigned WAIT_CYC   = WAIT_MS * CLK_KHZ; // Cycles per wait
  localparam int unsigned SYNC_WIDTH = 7;                 // Synchronised pin inputs

  // ==========================================================
  // Sequencer states, Gray along the power-up path
  typedef enum logic [2:0] {
    ST_OFF  = 3'b000,
    ST_REG  = 3'b001,
    ST_PUMP = 3'b011,
    ST_CLK  = 3'b010,
    ST_RUN  = 3'b110
  } seq_state_t;

  // ==========================================================
  // Microphone bias modes
  typedef enum logic [1:0] {
    BIAS_1V  = 2'b00,
    BIAS_2V  = 2'b01,
    BIAS_GND = 2'b10,
    BIAS_HIZ = 2'b11
  } bias_mode_t;

  // ==========================================================
  // Register map and fields
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int unsigned CTRL_BIAS_LSB  = 0;  // [1:0] bias mode in use
  localparam int unsigned CTRL_SLEEP_BIT = 2;  // System sleep
  localparam int unsigned CTRL_LSI_BIT   = 3;  // Straps as level-sense inputs
  localparam int unsigned CTRL_AUDIO_BIT = 4;  // Audio output enable request
  localparam logic [4:0]  CTRL_RST       = 5'h19; // Audio on, level sense, 2 V

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== logic/pin_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 7
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] agree;

  // Second and third stages agree
  assign agree = ~(s2_reg ^ s3_reg);

  // Shift chain; first stage feeds only the second
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a change only once the later stages agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      level <= '0;
    end else begin
      level <= (agree & s3_reg) | (~agree & level);
    end
  end

endmodule

// ==== logic/wait_timer.sv ====
// Saturating wait counter with synchronous clear
`timescale 1ns/1ns
module wait_timer #(
  parameter int unsigned LIMIT = 500000
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic clear,
  output logic      done
);

  logic [31:0] cnt_reg;

  // Count up to the limit, restart on clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 32'h0;
    end else if (clear) begin
      cnt_reg <= 32'h0;
    end else if (cnt_reg != LIMIT) begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  // Pure count compare; gating with clear would loop back through the caller
  assign done = (cnt_reg == LIMIT);

endmodule

// ==== logic/power_on_reset_sequencer.sv ====
// Power-on reset sequencer with supply supervision and AXI4-Lite registers
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ns
module power_on_reset_sequencer
  import por_seq_pkg::*;
#(
  parameter int unsigned WAIT_CYCLES = por_seq_pkg::WAIT_CYC
) (
  input  wire logic               mclk,
  input  wire logic               resetn,
  // Supply comparators and pins
  input  wire logic               supply_above_start,
  input  wire logic               supply_below_shut,
  input  wire logic               clock_strap_pin,
  input  wire logic               boot_strap_pin,
  input  wire logic               channel_strap_pin,
  input  wire logic               tuning_strap_pin,
  input  wire logic               channel_swap_pin,
  // Sequencer outputs
  output logic                    regulator_en,
  output logic                    analog_pump_rail_en,
  output logic                    system_clock_tree_en,
  output logic                    core_release,
  output logic                    audio_out_en,
  output por_seq_pkg::bias_mode_t mic_bias_output,
  output logic                    swap_pullup_en,
  output logic [3:0]              strap_pullup_en,
  output logic [3:0]              strap_pulldown_en,
  // AXI4-Lite slave
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);
  import por_seq_pkg::*;

  // ==========================================================
  // Input synchronisation
  logic [SYNC_WIDTH-1:0] pins_sync;
  logic                  above_s;
  logic                  below_s;
  logic [3:0]            straps_s;
  logic                  swap_s;

  pin_sync #(
    .WIDTH (SYNC_WIDTH)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin_in ({channel_swap_pin, tuning_strap_pin, channel_strap_pin,
              boot_strap_pin, clock_strap_pin, supply_below_shut,
              supply_above_start}),
    .level  (pins_sync)
  );

  assign above_s  = pins_sync[0];
  assign below_s  = pins_sync[1];
  assign straps_s = pins_sync[5:2];
  assign swap_s   = pins_sync[6];

  // ==========================================================
  // Sequencer state machine
  seq_state_t state_reg;
  seq_state_t state_next;
  logic       tmr_clear;
  logic       tmr_done;
  logic       por_rstn;
  logic [4:0] ctrl_reg;

  // Timer restarts on every state change and on loss of the start level while in ST_REG
  // restart wait timing
  assign tmr_clear = (state_next != state_reg) || ((state_reg == ST_REG) && !above_s);

  wait_timer #(
    .LIMIT (WAIT_CYCLES)
  ) u_timer (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (tmr_clear),
    .done   (tmr_done)
  );

  // Next-state decode
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (above_s && !below_s) begin
          state_next = ST_REG;
        end
      end
      ST_REG: begin
        if (tmr_done && above_s) begin
          state_next = ST_PUMP;
        end
      end
      ST_PUMP: begin
        if (tmr_done) begin
          state_next = ST_CLK;
        end
      end
      ST_CLK: begin
        state_next = ST_RUN;
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    if (below_s) begin
      state_next = ST_OFF;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Power outputs, registered from the next state
  // enable order and shutdown
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regulator_en         <= 1'b0;
      analog_pump_rail_en  <= 1'b0;
      system_clock_tree_en <= 1'b0;
      core_release         <= 1'b0;
    end else begin
      regulator_en         <= (state_next != ST_OFF);
      analog_pump_rail_en  <= (state_next == ST_PUMP) || (state_next == ST_CLK) ||
                              (state_next == ST_RUN);
      system_clock_tree_en <= (state_next == ST_CLK) || (state_next == ST_RUN);
      core_release         <= (state_next == ST_RUN);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      audio_out_en <= 1'b0;
    end else begin
      audio_out_en <= (state_next == ST_RUN) && core_release && ctrl_reg[CTRL_AUDIO_BIT];
    end
  end

  // bias mode, high impedance when asleep or down
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mic_bias_output <= BIAS_HIZ;
    end else if ((state_next == ST_RUN) && core_release && !ctrl_reg[CTRL_SLEEP_BIT]) begin
      mic_bias_output <= bias_mode_t'(ctrl_reg[CTRL_BIAS_LSB +: 2]);
    end else begin
      mic_bias_output <= BIAS_HIZ;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      swap_pullup_en    <= 1'b1;
      strap_pullup_en   <= 4'h0;
      strap_pulldown_en <= 4'hf;
    end else begin
      swap_pullup_en    <= 1'b1;
      strap_pullup_en   <= ctrl_reg[CTRL_LSI_BIT] ? 4'h0 : 4'hf;
      strap_pulldown_en <= ctrl_reg[CTRL_LSI_BIT] ? 4'hf : 4'h0;
    end
  end

  // ==========================================================
  // Configuration register, reset asynchronously outside run
  // config reset at sequence start
  assign por_rstn = resetn & core_release;

  logic        aw_free_reg;
  logic        w_free_reg;
  logic [7:0]  awaddr_hold;
  logic [31:0] wdata_hold;
  logic [3:0]  wstrb_hold;
  logic        wr_commit;

  // Write completes once address and data are both held
  assign wr_commit = !aw_free_reg && !w_free_reg && !s_axi_bvalid;

  // Control register write
  always_ff @(posedge mclk or negedge por_rstn) begin
    if (!por_rstn) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_commit && (awaddr_hold == CTRL_OFS) && wstrb_hold[0]) begin
      ctrl_reg <= wdata_hold[4:0];
    end
  end

  // ==========================================================
  // AXI4-Lite write channels
  assign s_axi_awready = aw_free_reg;
  assign s_axi_wready  = w_free_reg;

  // Address capture
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_free_reg <= 1'b1;
      awaddr_hold <= 8'h00;
    end else if (aw_free_reg && s_axi_awvalid) begin
      aw_free_reg <= 1'b0;
      awaddr_hold <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_free_reg <= 1'b1;
    end
  end

  // Data capture
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      w_free_reg <= 1'b1;
      wdata_hold <= 32'h0;
      wstrb_hold <= 4'h0;
    end else if (w_free_reg && s_axi_wvalid) begin
      w_free_reg <= 1'b0;
      wdata_hold <= s_axi_wdata;
      wstrb_hold <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_free_reg <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= ((awaddr_hold == CTRL_OFS) || (awaddr_hold == STATUS_OFS)) ?
                      RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channels
  logic [31:0] status_word;

  // Live sequencer and pin state
  assign status_word = {21'h0, swap_s, straps_s, core_release, below_s, above_s, state_reg};

  // Read address and data
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      case (s_axi_araddr)
        CTRL_OFS: begin
          s_axi_rdata <= {27'h0, ctrl_reg};
          s_axi_rresp <= RESP_OKAY;
        end
        STATUS_OFS: begin
          s_axi_rdata <= status_word;
          s_axi_rresp <= RESP_OKAY;
        end
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  logic [31:0] hold_cnt;
  logic [31:0] pump_age;

  // Helper counts: supply held above start, time since pump enable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hold_cnt <= 32'h0;
      pump_age <= 32'h0;
    end else begin
      hold_cnt <= above_s ? hold_cnt + 32'h1 : 32'h0;
      pump_age <= analog_pump_rail_en ? pump_age + 32'h1 : 32'h0;
    end
  end

  AST_CFG_DEFAULT: assert property (@(posedge mclk) disable iff (!resetn)
    !core_release |-> (ctrl_reg == CTRL_RST))
    else $error("config register not at default outside run");

  AST_AUDIO_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (state_reg != ST_RUN) |-> !audio_out_en)
    else $error("audio enabled before sequence done");

  AST_START_GATE: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(regulator_en) |-> $past(above_s))
    else $error("regulators enabled without startup level");

  AST_SHUT_RESET: assert property (@(posedge mclk) disable iff (!resetn)
    below_s |=> (state_reg == ST_OFF) ##1 !core_release)
    else $error("no reset after supply below shutdown");

  AST_PUMP_WAIT: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(analog_pump_rail_en) |-> (hold_cnt > WAIT_CYCLES))
    else $error("charge pump enabled too early");

  AST_CORE_WAIT: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(core_release) |-> (pump_age > WAIT_CYCLES))
    else $error("core released too early after pump");

  AST_ORDER: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(core_release) |-> $past(system_clock_tree_en) && analog_pump_rail_en && regulator_en)
    else $error("power-up order violated");

  AST_SHUTDOWN_ALL: assert property (@(posedge mclk) disable iff (!resetn)
    below_s |=> (!regulator_en && !analog_pump_rail_en && !audio_out_en &&
                 (mic_bias_output == BIAS_HIZ)))
    else $error("units still on after supply drop");

  AST_WAIT_ABORT: assert property (@(posedge mclk) disable iff (!resetn)
    ((state_reg inside {ST_REG, ST_PUMP}) && below_s) |=>
      (state_reg == ST_OFF) && !analog_pump_rail_en && !system_clock_tree_en)
    else $error("wait not abandoned on supply drop");

  AST_SLEEP_HIZ: assert property (@(posedge mclk) disable iff (!resetn)
    (core_release && ctrl_reg[CTRL_SLEEP_BIT]) |=> (mic_bias_output == BIAS_HIZ))
    else $error("bias not high impedance in sleep");

  AST_PULLS: assert property (@(posedge mclk) disable iff (!resetn)
    ctrl_reg[CTRL_LSI_BIT] |=> (strap_pullup_en == 4'h0) && (strap_pulldown_en == 4'hf))
    else $error("strap pulls wrong in level-sense mode");

  AST_SWAP_PULL: assert property (@(posedge mclk) disable iff (!resetn)
    swap_pullup_en)
    else $error("swap pin pull-up disabled");

endmodule

// ==== dv/supply_comparators.sv ====
// Battery supply comparator model standing in for the supply monitor
`timescale 1ns/1ns
module supply_comparators (
  input  wire logic [1:0] level_sel,
  output logic            supply_above_start,
  output logic            supply_below_shut
);
  // ==========================================================
  // Comparator levels
  // Select 0 is a sagged supply, 1 sits inside the hysteresis band, 2 is healthy
  // Inside the band both flags are low, so neither start nor shutdown is reported
  always_comb begin
    supply_above_start = (level_sel == 2'h2);
    supply_below_shut  = (level_sel == 2'h0);
  end
endmodule

// ==== dv/power_on_reset_sequencer_tb_top.sv ====
// Self-checking testbench for the power-on reset sequencer
`timescale 1ns/1ns
module power_on_reset_sequencer_tb_top;
  import por_seq_pkg::*;
  localparam int unsigned WAIT_N = 20; // Short waits for simulation
  logic        mclk, resetn, supply_above_start, supply_below_shut;
  logic [1:0]  level_sel;
  logic        clock_strap_pin, boot_strap_pin, channel_strap_pin, tuning_strap_pin, channel_swap_pin;
  logic        regulator_en, analog_pump_rail_en, system_clock_tree_en, core_release, audio_out_en;
  logic        swap_pullup_en;
  bias_mode_t  mic_bias_output;
  logic [3:0]  strap_pullup_en, strap_pulldown_en, s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          miscompares, num_checks;

  // ==========================================================
  // Instances
  supply_comparators i_supply (.level_sel, .supply_above_start, .supply_below_shut);

  power_on_reset_sequencer #(
    .WAIT_CYCLES(WAIT_N)
  ) i_dut (
    .mclk, .resetn, .supply_above_start, .supply_below_shut,
    .clock_strap_pin, .boot_strap_pin, .channel_strap_pin, .tuning_strap_pin, .channel_swap_pin,
    .regulator_en, .analog_pump_rail_en, .system_clock_tree_en, .core_release, .audio_out_en,
    .mic_bias_output, .swap_pullup_en, .strap_pullup_en, .strap_pulldown_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================
  // Comparison and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // sole host access path
  // Bus master: address and data offered together, held until taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    check("write wait", 32'(n < 50), 32'h1);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d    = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check("read wait", 32'(n < 50), 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, d, r);
    check("write resp", r, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check("read data", d, ed);
    check("read resp", r, er);
  endtask

  // ==========================================================
  // Power sequence helpers
  function automatic logic pwr(input int w);
    logic [3:0] v;
    v = {core_release, system_clock_tree_en, analog_pump_rail_en, regulator_en};
    return v[w];
  endfunction

  // Counts edges until enable w reaches val, bounded
  task automatic wait_lvl(input int w, input logic val, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (pwr(w) !== val && n < 3 * WAIT_N);
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic power_up();
    int n;
    @(posedge mclk);
    level_sel <= 2'h2;
    wait_lvl(0, 1'b1, n);
    check("regulator delay", 32'(n <= 8), 32'h1);
    wait_lvl(1, 1'b1, n);
    check("pump delay", n, WAIT_N + 1);
    check("audio in pump", audio_out_en, 1'b0);
    check("clock early", system_clock_tree_en, 1'b0);
    wait_lvl(2, 1'b1, n);
    check("clock delay", n, WAIT_N + 1);
    check("core early", core_release, 1'b0);
    check("audio in clock", audio_out_en, 1'b0);
    wait_lvl(3, 1'b1, n);
    check("core delay", n, 1);
    check("audio at release", audio_out_en, 1'b0);
    // Audio and bias follow one edge after core release
    @(posedge mclk);
    #1;
    check("audio run", audio_out_en, 1'b1);
    check("bias run", mic_bias_output, BIAS_2V);
  endtask

  task automatic sag_check();
    int n;
    @(posedge mclk);
    level_sel <= 2'h0;
    wait_lvl(0, 1'b0, n);
    check("shutdown delay", 32'(n <= 8), 32'h1);
    check("power outputs", {core_release, system_clock_tree_en, analog_pump_rail_en, audio_out_en}, 4'h0);
    check("bias off", mic_bias_output, BIAS_HIZ);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    miscompares = 0;
    num_checks = 0;
    resetn = 1'b0;
    level_sel = 2'h0;
    clock_strap_pin = 1'b1;
    boot_strap_pin = 1'b0;
    channel_strap_pin = 1'b1;
    tuning_strap_pin = 1'b0;
    channel_swap_pin = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    check("bias reset", mic_bias_output, BIAS_HIZ);
    check("swap pull-up", swap_pullup_en, 1'b1);
    check("strap pulls", {strap_pullup_en, strap_pulldown_en}, 8'h0f);
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    rd(CTRL_OFS, 32'h19, RESP_OKAY);
    // Supply inside the band must not start anything
    @(posedge mclk);
    level_sel <= 2'h1;
    repeat (40) @(posedge mclk);
    #1;
    check("no start in band", regulator_en, 1'b0);
    rd(STATUS_OFS, 32'h540, RESP_OKAY);
    power_up();
    rd(STATUS_OFS, 32'h56e, RESP_OKAY);
    // Every bias mode, then sleep, strap pulls and audio request
    for (int m = 0; m < 4; m++) begin
      wr(CTRL_OFS, 32'h18 | m, RESP_OKAY);
      settle();
      check("bias mode", mic_bias_output, m[1:0]);
      rd(CTRL_OFS, 32'h18 | m, RESP_OKAY);
    end
    // Write without the low byte strobe leaves the register alone
    s_axi_wstrb <= 4'he;
    wr(CTRL_OFS, 32'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(CTRL_OFS, 32'h1b, RESP_OKAY);
    wr(CTRL_OFS, 32'h1d, RESP_OKAY);
    settle();
    check("bias sleep", mic_bias_output, BIAS_HIZ);
    wr(CTRL_OFS, 32'h11, RESP_OKAY);
    settle();
    check("gpio pulls", {strap_pullup_en, strap_pulldown_en}, 8'hf0);
    check("bias awake", mic_bias_output, BIAS_2V);
    wr(CTRL_OFS, 32'h09, RESP_OKAY);
    settle();
    check("audio off", audio_out_en, 1'b0);
    rd(8'h08, 32'h0, RESP_SLVERR);
    wr(STATUS_OFS, 32'hffffffff, RESP_OKAY);
    rd(STATUS_OFS, 32'h56e, RESP_OKAY);
    // Sag in run, then configuration back at defaults
    sag_check();
    rd(CTRL_OFS, 32'h19, RESP_OKAY);
    rd(STATUS_OFS, 32'h550, RESP_OKAY);
    // Sag in the middle of the first wait abandons the sequence
    @(posedge mclk);
    level_sel <= 2'h2;
    wait_lvl(0, 1'b1, n);
    repeat (10) @(posedge mclk);
    level_sel <= 2'h0;
    wait_lvl(0, 1'b0, n);
    check("abort delay", 32'(n <= 8), 32'h1);
    check("pump after abort", analog_pump_rail_en, 1'b0);
    power_up();
    sag_check();
    complete_run();
  end

  // Watchdog against a hung wait
  initial begin
    repeat (40 * WAIT_N + 3000) @(posedge mclk);
    miscompares++;
    complete_run();
  end
endmodule
